// *** hw/synth_prog_defs.vh ***
// Offsets, field positions, reset values and frame layout of the divider program port
`ifndef SYNTH_PROG_DEFS_VH
`define SYNTH_PROG_DEFS_VH

// Register byte offsets
`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_SHIFT_OFS 4'h8
`define REG_ADR_W 4

// Control register fields
`define CTRL_SOFT_RESET_BIT 0
`define CTRL_RESET_VAL 1'h0

// Status register fields
`define STAT_FB_LSB 0
`define STAT_FB_MSB 8
`define STAT_ND_LSB 9
`define STAT_ND_MSB 10
`define STAT_SPREAD_BIT 11
`define STAT_HELD_BIT 12
`define STAT_RESET_BIT 13
`define STAT_REF_BIT 14
`define STAT_BYPASS_BIT 15
`define STAT_RATIO_LSB 16
`define STAT_RATIO_MSB 19

// Divider widths and reset values
`define FB_W 9
`define ND_W 2
`define FB_RESET_VAL 9'h07D
`define ND_RESET_VAL 2'h1
`define ND_PARALLEL_VAL 2'h1
`define SPREAD_RESET_VAL 1'h0

// Serial frame: spread bit, two output-divider bits, nine feedback bits, MSB first
`define FRAME_W 12
`define FRAME_SPREAD_BIT 11
`define FRAME_ND_MSB 10
`define FRAME_ND_LSB 9
`define FRAME_FB_MSB 8
`define FRAME_FB_LSB 0

// Reference pre-divide and tick weighting of the VCO model
`define REF_PREDIV 16
`define VCO_TICK_THRESH 12'h008
`define VCO_ACC_W 12

`endif

// *** hw/vco_tick_model.v ***
// Behavioural VCO: turns reference edges into half-period ticks at 2M/16 times the reference
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_defs.vh"

module vco_tick_model #(
  parameter FB_W = `FB_W,
  parameter ACC_W = `VCO_ACC_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire hold,
  // Reference edge and ratio
  input wire ref_edge,
  input wire [FB_W-1:0] fb_ratio,
  // Tick out
  output reg vco_tick
);

  reg [ACC_W-1:0] acc_q;
  reg [ACC_W-1:0] acc_d;
  reg tick_d;

  // Each reference edge is half a period, so it owes M/8 output toggles
  always @*
  begin
    acc_d = acc_q;
    tick_d = 1'b0;
    if (acc_q >= `VCO_TICK_THRESH)
    begin
      acc_d = acc_q - `VCO_TICK_THRESH;
      tick_d = 1'b1;
    end
    if (ref_edge)
      acc_d = acc_d + {{(ACC_W-FB_W){1'b0}}, fb_ratio};
  end

  // One tick per system cycle at most; faster requests pile up in the accumulator
  always @(posedge clk_sys)
  begin
    if (!reset_n || hold)
    begin
      acc_q <= {ACC_W{1'b0}};
      vco_tick <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      vco_tick <= tick_d;
    end
  end

endmodule // vco_tick_model
`default_nettype wire

// *** hw/out_clk_divider.v ***
// Output divider: toggles the output phase once every ratio ticks
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_defs.vh"

module out_clk_divider #(
  parameter RATIO_W = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  input wire hold,
  // Ticks and ratio
  input wire tick,
  input wire [RATIO_W-1:0] ratio,
  // Divided phase
  output reg phase
);

  reg [RATIO_W-1:0] cnt_q;

  always @(posedge clk_sys)
  begin
    if (!reset_n || hold)
    begin
      cnt_q <= {RATIO_W{1'b0}};
      phase <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_q + 1'b1 >= ratio)
      begin
        cnt_q <= {RATIO_W{1'b0}};
        phase <= ~phase;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // out_clk_divider
`default_nettype wire

// *** hw/synth_divider_program_port.v ***
// Divider program port: parallel and serial loading, master reset, outputs, Wishbone registers
// Operation
// - Master reset high forces outputs low, complements high.
// - Master reset low releases dividers and outputs.
// - Master reset keeps the loaded feedback value.
// - Serial data shifts in on shift clock rise.
// - Parallel strobe low passes pins to feedback divider.
// - Parallel strobe rise latches pins until next event.
// - Serial load rise transfers shift register to dividers.
// - Serial load fall latches divider values against shifting.
// - Serial load high shifts data straight into dividers.
// - Feedback ratio is plain nine-bit binary value.
// - Output code 00,01,10,11 divides by 1,2,4,8.
// - Output divider defaults to divide by two.
// - Spread bit: 0 off, 1 on, default off.
// - Reference select high picks oscillator, low test clock.
// - Bypass select 0 skips PLL, 1 synthesizes.
// - Parallel programming forces output divide by two.
// - Output equals reference/16 times 2M over N.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_defs.vh"

module synth_divider_program_port #(
  parameter FB_W = `FB_W,
  parameter ND_W = `ND_W,
  parameter FRAME_W = `FRAME_W,
  parameter OUT_PAIRS = 4
) (
  // System clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`REG_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Master reset and parallel load pins
  input wire master_reset_in,
  input wire parallel_load_strobe_n,
  input wire [FB_W-1:0] feedback_divider_pins,
  // Serial shift interface
  input wire serial_shift_clk,
  input wire serial_data_in,
  input wire serial_load_strobe,
  // Reference and mode selects
  input wire ref_source_select,
  input wire pll_bypass_select,
  input wire osc_input,
  input wire test_clk_in,
  // Oscillator drive and clock outputs
  output reg osc_output,
  output reg [OUT_PAIRS-1:0] clk_out_true,
  output reg [OUT_PAIRS-1:0] clk_out_comp,
  // Loaded divider state
  output reg [FB_W-1:0] fb_divider_value,
  output reg out_div_sel_hi,
  output reg out_div_sel_lo,
  output reg spread_enable_bit,
  output reg ref_is_osc,
  output reg pll_bypass_active
);

  localparam RATIO_W = 4;

  // Loader states, one-hot
  localparam ST_TRACK = 3'b001;
  localparam ST_HELD = 3'b010;
  localparam ST_SERIAL = 3'b100;

  // Output divide ratio for a two-bit code
  function [RATIO_W-1:0] nd_ratio;
    input [ND_W-1:0] code;
    begin
      case (code)
        2'h0: nd_ratio = 4'h1;
        2'h1: nd_ratio = 4'h2;
        2'h2: nd_ratio = 4'h4;
        2'h3: nd_ratio = 4'h8;
        default: nd_ratio = 4'h2;
      endcase
    end
  endfunction

  // Register file state
  reg soft_reset_q;
  reg wb_ack_q;
  reg [31:0] rd_data_d;

  // Loader state
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [FB_W-1:0] fb_q;
  reg [FB_W-1:0] fb_d;
  reg [ND_W-1:0] nd_q;
  reg [ND_W-1:0] nd_d;
  reg spread_q;
  reg spread_d;
  reg [FRAME_W-1:0] shift_q;
  reg [FRAME_W-1:0] shift_d;
  reg [FRAME_W-1:0] direct_frame;

  // Edge detection on pins sampled as synchronous inputs
  reg pload_n_prev_q;
  reg sclk_prev_q;
  reg sload_prev_q;
  reg ref_prev_q;

  wire reset_active;
  wire pload_rise;
  wire sclk_rise;
  wire sload_rise;
  wire sload_fall;
  wire ref_level;
  wire ref_edge;
  wire vco_tick;
  wire div_tick;
  wire div_phase;
  wire bus_req;

  assign reset_active = master_reset_in | soft_reset_q;
  assign pload_rise = parallel_load_strobe_n & ~pload_n_prev_q;
  assign sclk_rise = serial_shift_clk & ~sclk_prev_q;
  assign sload_rise = serial_load_strobe & ~sload_prev_q;
  assign sload_fall = ~serial_load_strobe & sload_prev_q;
  assign ref_level = ref_source_select ? osc_input : test_clk_in;
  assign ref_edge = ref_level ^ ref_prev_q;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      // High, so a strobe held high through reset is not seen as a rise
      pload_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      sload_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      pload_n_prev_q <= parallel_load_strobe_n;
      sclk_prev_q <= serial_shift_clk;
      sload_prev_q <= serial_load_strobe;
      ref_prev_q <= ref_level;
    end
  end

  // Frame as it would stand after one more bit goes straight into the dividers
  always @*
  begin
    direct_frame = {spread_q, nd_q, fb_q};
    direct_frame = {direct_frame[FRAME_W-2:0], serial_data_in};
  end

  // Loader: all loading frozen during master reset so the held value survives it
  always @*
  begin
    state_d = state_q;
    fb_d = fb_q;
    nd_d = nd_q;
    spread_d = spread_q;
    shift_d = shift_q;
    if (!reset_active)
    begin
      if (!parallel_load_strobe_n)
      begin
        fb_d = feedback_divider_pins;
        nd_d = `ND_PARALLEL_VAL;
        state_d = ST_TRACK;
      end
      else if (pload_rise)
      begin
        fb_d = feedback_divider_pins;
        nd_d = `ND_PARALLEL_VAL;
        state_d = ST_HELD;
      end
      else
      begin
        case (state_q)
          ST_TRACK, ST_HELD:
          begin
            if (serial_load_strobe && sload_rise)
            begin
              spread_d = shift_q[`FRAME_SPREAD_BIT];
              nd_d = shift_q[`FRAME_ND_MSB:`FRAME_ND_LSB];
              fb_d = shift_q[`FRAME_FB_MSB:`FRAME_FB_LSB];
              state_d = ST_SERIAL;
            end
            else if (!serial_load_strobe && sclk_rise)
              shift_d = {shift_q[FRAME_W-2:0], serial_data_in};
          end
          ST_SERIAL:
          begin
            if (sload_rise)
            begin
              spread_d = shift_q[`FRAME_SPREAD_BIT];
              nd_d = shift_q[`FRAME_ND_MSB:`FRAME_ND_LSB];
              fb_d = shift_q[`FRAME_FB_MSB:`FRAME_FB_LSB];
            end
            else if (serial_load_strobe && sclk_rise)
            begin
              spread_d = direct_frame[`FRAME_SPREAD_BIT];
              nd_d = direct_frame[`FRAME_ND_MSB:`FRAME_ND_LSB];
              fb_d = direct_frame[`FRAME_FB_MSB:`FRAME_FB_LSB];
            end
            else if (!serial_load_strobe && sclk_rise)
              shift_d = {shift_q[FRAME_W-2:0], serial_data_in};
            if (sload_fall)
              state_d = ST_HELD;
          end
          default:
            state_d = ST_HELD;
        endcase
      end
    end
  end

  // Divider values and shift register; reset gives the power-up defaults
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q <= ST_HELD;
      fb_q <= `FB_RESET_VAL;
      nd_q <= `ND_RESET_VAL;
      spread_q <= `SPREAD_RESET_VAL;
      shift_q <= {FRAME_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      fb_q <= fb_d;
      nd_q <= nd_d;
      spread_q <= spread_d;
      shift_q <= shift_d;
    end
  end

  // Clock path: PLL model or bypass, then the output divider
  vco_tick_model #(
    .FB_W(FB_W),
    .ACC_W(`VCO_ACC_W)
  ) u_vco (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hold(reset_active),
    .ref_edge(ref_edge),
    .fb_ratio(fb_q),
    .vco_tick(vco_tick)
  );

  assign div_tick = pll_bypass_select ? vco_tick : ref_edge;

  out_clk_divider #(
    .RATIO_W(RATIO_W)
  ) u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hold(reset_active),
    .tick(div_tick),
    .ratio(nd_ratio(nd_q)),
    .phase(div_phase)
  );

  // Output pairs, each from its own flop so the pins never glitch
  genvar gi;
  generate
    for (gi = 0; gi < OUT_PAIRS; gi = gi + 1)
    begin : g_out
      always @(posedge clk_sys)
      begin
        if (!reset_n || reset_active)
        begin
          clk_out_true[gi] <= 1'b0;
          clk_out_comp[gi] <= 1'b1;
        end
        else
        begin
          clk_out_true[gi] <= div_phase;
          clk_out_comp[gi] <= ~div_phase;
        end
      end
    end
  endgenerate

  // Registered view of the loaded state
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      osc_output <= 1'b1;
      fb_divider_value <= `FB_RESET_VAL;
      out_div_sel_hi <= 1'b0;
      out_div_sel_lo <= 1'b1;
      spread_enable_bit <= `SPREAD_RESET_VAL;
      ref_is_osc <= 1'b1;
      pll_bypass_active <= 1'b0;
    end
    else
    begin
      osc_output <= ~osc_input;
      fb_divider_value <= fb_q;
      out_div_sel_hi <= nd_q[1];
      out_div_sel_lo <= nd_q[0];
      spread_enable_bit <= spread_q;
      ref_is_osc <= ref_source_select;
      pll_bypass_active <= ~pll_bypass_select;
    end
  end

  // Wishbone read mux; unmapped offsets read zero
  always @*
  begin
    rd_data_d = 32'h00000000;
    case (wb_adr_i)
      `REG_CTRL_OFS:
        rd_data_d[`CTRL_SOFT_RESET_BIT] = soft_reset_q;
      `REG_STATUS_OFS:
      begin
        rd_data_d[`STAT_FB_MSB:`STAT_FB_LSB] = fb_q;
        rd_data_d[`STAT_ND_MSB:`STAT_ND_LSB] = nd_q;
        rd_data_d[`STAT_SPREAD_BIT] = spread_q;
        rd_data_d[`STAT_HELD_BIT] = ~state_q[0];
        rd_data_d[`STAT_RESET_BIT] = reset_active;
        rd_data_d[`STAT_REF_BIT] = ref_source_select;
        rd_data_d[`STAT_BYPASS_BIT] = ~pll_bypass_select;
        rd_data_d[`STAT_RATIO_MSB:`STAT_RATIO_LSB] = nd_ratio(nd_q);
      end
      `REG_SHIFT_OFS:
        rd_data_d[FRAME_W-1:0] = shift_q;
      default:
        rd_data_d = 32'h00000000;
    endcase
  end

  // One wait state: ack rises the edge after the request and drops the next
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wb_ack_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      soft_reset_q <= `CTRL_RESET_VAL;
    end
    else
    begin
      wb_ack_q <= bus_req;
      wb_ack_o <= bus_req;
      if (bus_req)
        wb_dat_o <= rd_data_d;
      if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL_OFS)
        soft_reset_q <= wb_dat_i[`CTRL_SOFT_RESET_BIT];
    end
  end

endmodule // synth_divider_program_port
`default_nettype wire

// *** tb/serial_ctl_model.sv ***
// Behavioural serial controller that programs the divider port
`timescale 1ns/1ps
`default_nettype none
module serial_ctl_model (
  // Clock
  input wire logic clk_sys,
  // Serial wires, idle low like their pulldowns
  output logic sclk = 1'b0,
  output logic sdata = 1'b0,
  output logic sload = 1'b0
);
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Three cycles per level: the port samples pins and needs two
  task automatic shift(input logic [11:0] f);
    for (int i = 11; i >= 0; i--)
    begin
      sdata <= f[i];
      wait_n(3);
      sclk <= 1'b1;
      wait_n(3);
      sclk <= 1'b0;
      sdata <= 1'b0;
      wait_n(3);
    end
  endtask
  task automatic set_load(input logic v);
    sload <= v;
    wait_n(3);
  endtask
endmodule // serial_ctl_model
`default_nettype wire

// *** tb/synth_port_checker.sv ***
// Assertions on the divider program port
`timescale 1ns/1ps
`default_nettype none
module synth_port_checker #(
  parameter FB_W = 9,
  parameter OUT_PAIRS = 4
) (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic master_reset_in,
  input wire logic parallel_load_strobe_n,
  input wire logic [FB_W-1:0] feedback_divider_pins,
  input wire logic serial_load_strobe,
  input wire logic ref_source_select,
  input wire logic pll_bypass_select,
  // Outputs
  input wire logic [OUT_PAIRS-1:0] clk_out_true,
  input wire logic [OUT_PAIRS-1:0] clk_out_comp,
  input wire logic [FB_W-1:0] fb_divider_value,
  input wire logic out_div_sel_hi,
  input wire logic out_div_sel_lo,
  input wire logic ref_is_osc,
  input wire logic pll_bypass_active,
  // Oscillator pins
  input wire logic osc_input,
  input wire logic osc_output
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_mr2;
    master_reset_in ##1 master_reset_in;
  endsequence
  sequence s_track2;
    (!master_reset_in && !parallel_load_strobe_n)[*2];
  endsequence
  property p_mr_out;
    master_reset_in |=> clk_out_true == 0 && clk_out_comp == {OUT_PAIRS{1'b1}};
  endproperty
  a_mr_out: assert property (p_mr_out) else $error("outputs not parked");
  property p_mr_keep;
    s_mr2 |=> $stable(fb_divider_value);
  endproperty
  a_mr_keep: assert property (p_mr_keep) else $error("feedback moved in reset");
  property p_comp;
    clk_out_comp == ~clk_out_true;
  endproperty
  a_comp: assert property (p_comp) else $error("pair not complementary");
  property p_track;
    s_track2 |=> fb_divider_value == $past(feedback_divider_pins, 2)
      && {out_div_sel_hi, out_div_sel_lo} == 2'h1;
  endproperty
  a_track: assert property (p_track) else $error("pins not tracked");
  property p_latch;
    (parallel_load_strobe_n && !serial_load_strobe)[*4] |=> $stable(fb_divider_value);
  endproperty
  a_latch: assert property (p_latch) else $error("held value moved");
  property p_sel;
    ##1 ref_is_osc == $past(ref_source_select) && pll_bypass_active == !$past(pll_bypass_select);
  endproperty
  a_sel: assert property (p_sel) else $error("select copy wrong");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_osc;
    reset_n |=> osc_output == !$past(osc_input);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator drive wrong");
endmodule // synth_port_checker
bind synth_divider_program_port synth_port_checker #(.FB_W(FB_W), .OUT_PAIRS(OUT_PAIRS)) i_chk (
  .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .master_reset_in,
  .parallel_load_strobe_n, .feedback_divider_pins, .serial_load_strobe, .ref_source_select,
  .pll_bypass_select, .clk_out_true, .clk_out_comp, .fb_divider_value, .out_div_sel_hi,
  .out_div_sel_lo, .ref_is_osc, .pll_bypass_active, .osc_input, .osc_output);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the divider program port
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [11:0] f; logic [3:0] r;} row_t;
  row_t rows [4] = '{'{12'h07D, 4'h1}, '{12'hB5E, 4'h2}, '{12'h500, 4'h4}, '{12'h6FF, 4'h8}};
  logic clk_sys, reset_n = 1'b0, master_reset_in = 1'b0, parallel_load_strobe_n = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, ref_source_select = 1'b1;
  logic pll_bypass_select = 1'b1;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic [8:0] feedback_divider_pins = 9'h000;
  logic [2:0] ph = 3'h0;
  wire osc_input = ph[2];
  wire test_clk_in = ph[1];
  wire [31:0] wb_dat_o;
  wire [3:0] clk_out_true, clk_out_comp;
  wire [8:0] fb_divider_value;
  wire wb_ack_o, osc_output, out_div_sel_hi, out_div_sel_lo, spread_enable_bit, ref_is_osc;
  wire pll_bypass_active, serial_shift_clk, serial_data_in, serial_load_strobe;
  wire [11:0] divs = {spread_enable_bit, out_div_sel_hi, out_div_sel_lo, fb_divider_value};
  int miscompares = 0, comparisons = 0, cycles = 0, n;
  serial_ctl_model i_serial_ctl_model (.clk_sys, .sclk(serial_shift_clk),
    .sdata(serial_data_in), .sload(serial_load_strobe));
  synth_divider_program_port i_synth_divider_program_port (.clk_sys, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .master_reset_in, .parallel_load_strobe_n, .feedback_divider_pins, .serial_shift_clk,
    .serial_data_in, .serial_load_strobe, .ref_source_select, .pll_bypass_select, .osc_input,
    .test_clk_in, .osc_output, .clk_out_true, .clk_out_comp, .fb_divider_value,
    .out_div_sel_hi, .out_div_sel_lo, .spread_enable_bit, .ref_is_osc, .pll_bypass_active);
  task automatic finish_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Waits as long as the slave needs; only the bench timeout ends a hang
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // Bypass mode: counts output toggles over 160 cycles for one reference source
  task automatic toggles(input logic rs, input int lo, input int hi);
    int t;
    logic last;
    t = 0;
    ref_source_select <= rs;
    pll_bypass_select <= 1'b0;
    repeat (20) @(posedge clk_sys);
    last = clk_out_true[0];
    repeat (160)
    begin
      @(posedge clk_sys);
      if (clk_out_true[0] !== last)
        t++;
      last = clk_out_true[0];
    end
    chk(t >= lo && t <= hi, 1);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    ph <= ph + 3'h1;
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    chk(32'(divs), 32'h27D);
    chk({ref_is_osc, pll_bypass_active, clk_out_true, clk_out_comp}, 32'h20F);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 32'h0, 32'hFFFFFFFF);
    foreach (rows[i])
    begin
      i_serial_ctl_model.shift(rows[i].f);
      i_serial_ctl_model.set_load(1'b1);
      i_serial_ctl_model.set_load(1'b0);
      chk(32'(divs), 32'(rows[i].f));
      rd(4'h8, 32'(rows[i].f), 32'hFFF);
      rd(4'h4, {12'h0, rows[i].r, 4'h5, rows[i].f}, 32'hFFFFF);
    end
    parallel_load_strobe_n <= 1'b0;
    feedback_divider_pins <= 9'h15E;
    repeat (4) @(posedge clk_sys);
    chk(32'(divs), 32'h35E);
    parallel_load_strobe_n <= 1'b1;
    @(posedge clk_sys);
    feedback_divider_pins <= 9'h0AA;
    repeat (4) @(posedge clk_sys);
    chk(32'(fb_divider_value), 32'h15E);
    i_serial_ctl_model.set_load(1'b1);
    chk(32'(divs), 32'h6FF);
    i_serial_ctl_model.shift(12'hB5E);
    chk(32'(divs), 32'hB5E);
    i_serial_ctl_model.set_load(1'b0);
    i_serial_ctl_model.shift(12'h07D);
    chk(32'(divs), 32'hB5E);
    rd(4'h8, 32'h07D, 32'hFFF);
    master_reset_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({clk_out_true, clk_out_comp}, 32'h0F);
    master_reset_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'(fb_divider_value), 32'h15E);
    n = 0;
    while (clk_out_true[0] !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 200, 1);
    wb(1'b1, 4'h0, 32'h1);
    rd(4'h0, 32'h1, 32'h1);
    rd(4'h4, 32'h2000, 32'h2000);
    chk({clk_out_true, clk_out_comp}, 32'h0F);
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0, 32'hFFFFFFFF);
    // Write with byte lane 0 off must leave CTRL alone
    wb_sel_i <= 4'hE;
    wb(1'b1, 4'h0, 32'h1);
    wb_sel_i <= 4'h1;
    rd(4'h0, 32'h0, 32'hFFFFFFFF);
    // Mid-run reset with the parallel strobe high: defaults return and stay
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(divs), 32'h27D);
    // Oscillator edges every 4 cycles, test clock every 2; divide by 2
    toggles(1'b1, 19, 21);
    toggles(1'b0, 39, 41);
    chk({ref_is_osc, pll_bypass_active}, 32'h1);
    finish_test;
  end
endmodule // tb
`default_nettype wire
